/* hdl/omc_pkg.sv */
// Package: offsets, field positions, reset values and mode codes of the mode control block
package omc_pkg;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses on the bus)
  // ---------------------------------------------------------------
  localparam logic [7:0] OMC_OPCTL_IDX = 8'h02;
  localparam logic [7:0] OMC_MODE_IDX = 8'h03;
  localparam logic [11:0] OMC_OPCTL_ADDR = {2'h0, OMC_OPCTL_IDX, 2'h0};
  localparam logic [11:0] OMC_MODE_ADDR = {2'h0, OMC_MODE_IDX, 2'h0};
  localparam logic [11:0] OMC_CMD_ADDR = 12'h010;
  localparam logic [11:0] OMC_STAT_ADDR = 12'h014;
  // ---------------------------------------------------------------
  // Operation control fields
  // ---------------------------------------------------------------
  localparam int OMC_OC_EN = 7;
  localparam int OMC_OC_RX_EN = 6;
  localparam int OMC_OC_RX_ONE = 5;
  localparam int OMC_OC_RX_MAN = 4;
  localparam int OMC_OC_TX_EN = 3;
  localparam int OMC_OC_WAKE = 2;
  localparam logic [7:0] OMC_OC_MASK = 8'hfc;
  localparam logic [7:0] OMC_OC_RESET = 8'h00;
  // ---------------------------------------------------------------
  // Mode definition fields
  // ---------------------------------------------------------------
  localparam int OMC_MD_TARGET = 7;
  localparam int OMC_MD_OM_HI = 6;
  localparam int OMC_MD_OM_LO = 3;
  localparam int OMC_MD_AUTO_RCA = 0;
  localparam logic [7:0] OMC_MD_MASK = 8'hf9;
  localparam logic [7:0] OMC_MD_RESET = 8'h08;
  // ---------------------------------------------------------------
  // Command register bits
  // ---------------------------------------------------------------
  localparam int OMC_CMD_SET_DEFAULT = 0;
  localparam int OMC_CMD_FIELD_ON = 1;
  // ---------------------------------------------------------------
  // Operating modes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OMC_OM_NONE,
    OMC_OM_I_PEER,
    OMC_OM_I_14A,
    OMC_OM_I_14B,
    OMC_OM_I_PROP,
    OMC_OM_I_T1T,
    OMC_OM_I_SUBC,
    OMC_OM_I_BPSK,
    OMC_OM_T_PEER_DET,
    OMC_OM_T_PEER_NORM
  } omc_mode_t;
endpackage : omc_pkg

/* hdl/omc_mode_decode.sv */
// Decoder from role bit and mode field to an operating mode
`timescale 1ns/10ps
module omc_mode_decode
  import omc_pkg::*;
(
  input wire logic target,
  input wire logic [3:0] om_field,
  output omc_mode_t mode,
  output logic mode_valid
);
  always_comb begin
    mode = OMC_OM_NONE;
    if (!target) begin
      case (om_field)
        4'h0: mode = OMC_OM_I_PEER;
        4'h1: mode = OMC_OM_I_14A;
        4'h2: mode = OMC_OM_I_14B;
        4'h3: mode = OMC_OM_I_PROP;
        4'h4: mode = OMC_OM_I_T1T;
        4'he: mode = OMC_OM_I_SUBC;
        4'hf: mode = OMC_OM_I_BPSK;
        default: mode = OMC_OM_NONE;
      endcase
    end else begin
      case (om_field)
        4'h0: mode = OMC_OM_T_PEER_DET;
        4'h1: mode = OMC_OM_T_PEER_NORM;
        default: mode = OMC_OM_NONE;
      endcase
    end
  end
  assign mode_valid = (mode != OMC_OM_NONE);
endmodule : omc_mode_decode

/* hdl/omc_rx_path.sv */
// Receive channel control derived from the operation control bits
`timescale 1ns/10ps
module omc_rx_path (
  input wire logic rx_on,
  input wire logic one_channel,
  input wire logic manual,
  input wire logic channel_pick,
  output logic am_active,
  output logic pm_active,
  output logic auto_select
);
  assign am_active = rx_on & (!one_channel | !channel_pick);
  assign pm_active = rx_on & (!one_channel | channel_pick);
  assign auto_select = rx_on & !one_channel & !manual;
endmodule : omc_rx_path

/* hdl/omc_top.sv */
// Operation control and mode definition registers with APB access
//
// Contract
// - Bit 7 powers oscillator and regulator
// - Bit 6 enables the receive path
// - Bit 5 picks both or one channel
// - Bit 4 picks automatic or manual choice
// - Bit 3 transmit; field-on sets, peer-done clears
// - Bit 2 enables wake-up mode
// - Operation control resets at power-up only
// - Mode bit 7 selects initiator or target
// - Bits 6..3 mode field, reset 0001
// - Initiator codes 0 to 4 map protocols
// - Initiator codes e and f stream modes
// - Target codes 0 and 1 peer modes
// - Undefined code disables transmit and receive
// - Mode bit 0 auto response collision avoidance
// - Mode register resets on set-default too
`timescale 1ns/10ps
module omc_top
  import omc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic channel_pick,
  input wire logic tx_done,
  output logic osc_reg_on,
  output logic ready_mode,
  output logic rx_enable,
  output logic rx_am_active,
  output logic rx_pm_active,
  output logic rx_auto_select,
  output logic tx_enable,
  output logic wake_mode_enable,
  output logic target_role,
  output logic [3:0] op_mode_field,
  output omc_mode_t op_mode,
  output logic mode_supported,
  output logic auto_response_collision_avoid
);
  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic [7:0] opctl_r;
  logic [7:0] mode_r;
  logic wr_acc;
  logic rd_acc;
  logic hit_opctl;
  logic hit_mode;
  logic hit_cmd;
  logic hit_stat;
  logic mapped;
  logic set_default;
  logic field_on_cmd;
  logic peer_mode;
  logic rx_gate;
  logic tx_gate;
  logic [7:0] opctl_nxt;
  logic [31:0] rdata_nxt;

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & !pwrite;
  assign hit_opctl = (paddr == OMC_OPCTL_ADDR);
  assign hit_mode = (paddr == OMC_MODE_ADDR);
  assign hit_cmd = (paddr == OMC_CMD_ADDR);
  assign hit_stat = (paddr == OMC_STAT_ADDR);
  assign mapped = hit_opctl | hit_mode | hit_cmd | hit_stat;
  assign pready = psel & penable;
  assign pslverr = psel & penable & !mapped;
  assign set_default = wr_acc & hit_cmd & pwdata[OMC_CMD_SET_DEFAULT];
  assign field_on_cmd = wr_acc & hit_cmd & pwdata[OMC_CMD_FIELD_ON];

  // ---------------------------------------------------------------
  // Operation control register
  // ---------------------------------------------------------------
  assign peer_mode = (op_mode == OMC_OM_I_PEER) | (op_mode == OMC_OM_T_PEER_DET) |
                     (op_mode == OMC_OM_T_PEER_NORM);

  always_comb begin
    opctl_nxt = opctl_r;
    if (wr_acc && hit_opctl) begin
      opctl_nxt = pwdata[7:0] & OMC_OC_MASK;
    end
    if (tx_done && peer_mode) begin
      opctl_nxt[OMC_OC_TX_EN] = 1'b0;
    end
    // field-on sets transmit, wins over clear
    if (field_on_cmd) begin
      opctl_nxt[OMC_OC_TX_EN] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      opctl_r <= OMC_OC_RESET;
    end else begin
      opctl_r <= opctl_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Mode definition register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    // reset at power-up and on set-default
    if (rst || set_default) begin
      mode_r <= OMC_MD_RESET;
    end else if (wr_acc && hit_mode) begin
      mode_r <= pwdata[7:0] & OMC_MD_MASK;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_opctl) begin
      rdata_nxt = {24'h00_0000, opctl_r};
    end else if (hit_mode) begin
      rdata_nxt = {24'h00_0000, mode_r};
    end else if (hit_stat) begin
      rdata_nxt = {27'h000_0000, mode_supported, op_mode};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Mode decode and gating
  // ---------------------------------------------------------------
  // role bit picks the code table
  assign target_role = mode_r[OMC_MD_TARGET];
  assign op_mode_field = mode_r[OMC_MD_OM_HI:OMC_MD_OM_LO];

  omc_mode_decode u_dec (
    .target(target_role),
    .om_field(op_mode_field),
    .mode(op_mode),
    .mode_valid(mode_supported)
  );

  assign osc_reg_on = opctl_r[OMC_OC_EN];
  assign ready_mode = opctl_r[OMC_OC_EN];
  // undefined mode blocks rx and tx
  assign rx_gate = opctl_r[OMC_OC_RX_EN] & mode_supported;
  assign tx_gate = opctl_r[OMC_OC_TX_EN] & mode_supported;
  assign rx_enable = rx_gate;
  assign tx_enable = tx_gate;
  assign wake_mode_enable = opctl_r[OMC_OC_WAKE];
  assign auto_response_collision_avoid = mode_r[OMC_MD_AUTO_RCA];

  omc_rx_path u_rx (
    .rx_on(rx_gate),
    .one_channel(opctl_r[OMC_OC_RX_ONE]),
    .manual(opctl_r[OMC_OC_RX_MAN]),
    .channel_pick(channel_pick),
    .am_active(rx_am_active),
    .pm_active(rx_pm_active),
    .auto_select(rx_auto_select)
  );

  // ---------------------------------------------------------------
  // Checks: reset and set-default
  // ---------------------------------------------------------------
  // power-up clear
  chk_opctl_reset: assert property (@(posedge ref_clk)
    rst |=> opctl_r == OMC_OC_RESET)
    else $error("operation control not cleared by reset");
  chk_mode_reset: assert property (@(posedge ref_clk)
    rst |=> mode_r == OMC_MD_RESET)
    else $error("mode definition not loaded by reset");
  chk_field_reset: assert property (@(posedge ref_clk)
    rst |=> op_mode_field == 4'h1 && !target_role)
    else $error("mode field reset value wrong");
  chk_opctl_keep_dflt: assert property (@(posedge ref_clk) disable iff (rst)
    (set_default && !(wr_acc && hit_opctl) && !field_on_cmd && !tx_done)
    |=> opctl_r == $past(opctl_r))
    else $error("set-default changed operation control");
  chk_mode_default: assert property (@(posedge ref_clk) disable iff (rst)
    set_default |=> mode_r == OMC_MD_RESET)
    else $error("set-default did not reload mode register");

  // ---------------------------------------------------------------
  // Checks: bus access
  // ---------------------------------------------------------------
  // unmapped read zero
  chk_unmapped_rd: assert property (@(posedge ref_clk) disable iff (rst)
    rd_acc && !mapped |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  chk_unmapped_wr: assert property (@(posedge ref_clk) disable iff (rst)
    wr_acc && !mapped && !tx_done |=> opctl_r == $past(opctl_r) && mode_r == $past(mode_r))
    else $error("unmapped write changed a register");
  chk_rd_opctl: assert property (@(posedge ref_clk) disable iff (rst)
    psel && !penable && !pwrite && hit_opctl |=> prdata == {24'h00_0000, $past(opctl_r)})
    else $error("operation control read data wrong");
  chk_rd_mode: assert property (@(posedge ref_clk) disable iff (rst)
    psel && !penable && !pwrite && hit_mode |=> prdata == {24'h00_0000, $past(mode_r)})
    else $error("mode definition read data wrong");
  chk_unused_zero: assert property (@(posedge ref_clk) disable iff (rst)
    opctl_r[1:0] == 2'h0 && mode_r[2:1] == 2'h0)
    else $error("unused bits not zero");

  // ---------------------------------------------------------------
  // Checks: operation control
  // ---------------------------------------------------------------
  // write sets oscillator
  chk_osc_on: assert property (@(posedge ref_clk) disable iff (rst)
    wr_acc && hit_opctl && pwdata[OMC_OC_EN] |=> osc_reg_on && ready_mode)
    else $error("oscillator not enabled by write");
  chk_osc_off: assert property (@(posedge ref_clk) disable iff (rst)
    wr_acc && hit_opctl && !pwdata[OMC_OC_EN] |=> !osc_reg_on && !ready_mode)
    else $error("oscillator not disabled by write");
  chk_rx_off: assert property (@(posedge ref_clk) disable iff (rst)
    !opctl_r[OMC_OC_RX_EN]
    |-> !rx_enable && !rx_am_active && !rx_pm_active && !rx_auto_select)
    else $error("receive active with enable cleared");
  chk_rx_on_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_acc && hit_opctl && pwdata[OMC_OC_RX_EN] && mode_supported |=> rx_enable)
    else $error("receive not enabled by write");
  chk_field_on_tx: assert property (@(posedge ref_clk) disable iff (rst)
    field_on_cmd |=> opctl_r[OMC_OC_TX_EN])
    else $error("field-on did not set transmit enable");
  chk_peer_tx_clear: assert property (@(posedge ref_clk) disable iff (rst)
    tx_done && peer_mode && !field_on_cmd && !(wr_acc && hit_opctl)
    |=> !opctl_r[OMC_OC_TX_EN])
    else $error("transmit enable not cleared after peer transmit");
  chk_tx_keep_other: assert property (@(posedge ref_clk) disable iff (rst)
    tx_done && !peer_mode && !field_on_cmd && !(wr_acc && hit_opctl)
    |=> opctl_r[OMC_OC_TX_EN] == $past(opctl_r[OMC_OC_TX_EN]))
    else $error("transmit enable cleared outside peer mode");
  chk_tx_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !tx_done && !field_on_cmd && !(wr_acc && hit_opctl)
    |=> opctl_r[OMC_OC_TX_EN] == $past(opctl_r[OMC_OC_TX_EN]))
    else $error("transmit enable changed without cause");
  chk_wake_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_acc && hit_opctl |=> wake_mode_enable == $past(pwdata[OMC_OC_WAKE]))
    else $error("wake-up enable does not follow write");

  // ---------------------------------------------------------------
  // Checks: mode definition
  // ---------------------------------------------------------------
  // role follows write
  chk_role_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_acc && hit_mode |=> target_role == $past(pwdata[OMC_MD_TARGET]))
    else $error("role bit does not follow write");
  chk_field_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_acc && hit_mode |=> op_mode_field == $past(pwdata[OMC_MD_OM_HI:OMC_MD_OM_LO]))
    else $error("mode field does not follow write");
  chk_init_14a: assert property (@(posedge ref_clk) disable iff (rst)
    !target_role && op_mode_field == 4'h1 |-> op_mode == OMC_OM_I_14A)
    else $error("code 1 not decoded as type a reader");
  chk_init_t1t: assert property (@(posedge ref_clk) disable iff (rst)
    !target_role && op_mode_field == 4'h4 |-> op_mode == OMC_OM_I_T1T)
    else $error("code 4 not decoded as type 1 tag reader");
  chk_subc_code: assert property (@(posedge ref_clk) disable iff (rst)
    !target_role && op_mode_field == 4'he |-> op_mode == OMC_OM_I_SUBC)
    else $error("code e not decoded as sub-carrier stream");
  chk_stream_codes: assert property (@(posedge ref_clk) disable iff (rst)
    !target_role && op_mode_field == 4'hf |-> op_mode == OMC_OM_I_BPSK)
    else $error("code f not decoded as bpsk stream");
  chk_target_codes: assert property (@(posedge ref_clk) disable iff (rst)
    target_role && op_mode_field > 4'h1 |-> !mode_supported)
    else $error("target accepted undefined code");
  chk_target_norm: assert property (@(posedge ref_clk) disable iff (rst)
    target_role && op_mode_field == 4'h1 |-> op_mode == OMC_OM_T_PEER_NORM)
    else $error("target code 1 not decoded as normal peer mode");
  chk_init_unused: assert property (@(posedge ref_clk) disable iff (rst)
    !target_role && (op_mode_field inside {[4'h5:4'hd]}) |-> !mode_supported)
    else $error("initiator accepted undefined code");
  chk_bad_mode_off: assert property (@(posedge ref_clk) disable iff (rst)
    !mode_supported |-> !rx_enable && !tx_enable && !rx_am_active && !rx_pm_active)
    else $error("rx or tx active with undefined mode");
  chk_auto_rca: assert property (@(posedge ref_clk) disable iff (rst)
    wr_acc && hit_mode |=> auto_response_collision_avoid == $past(pwdata[OMC_MD_AUTO_RCA]))
    else $error("collision avoidance bit does not follow write");

  // ---------------------------------------------------------------
  // Checks: receive channels
  // ---------------------------------------------------------------
  // one channel active
  chk_one_channel: assert property (@(posedge ref_clk) disable iff (rst)
    rx_enable && opctl_r[OMC_OC_RX_ONE] |-> rx_am_active != rx_pm_active)
    else $error("one-channel mode has wrong channel count");
  chk_both_channels: assert property (@(posedge ref_clk) disable iff (rst)
    rx_enable && !opctl_r[OMC_OC_RX_ONE] |-> rx_am_active && rx_pm_active)
    else $error("both-channel mode lost a channel");
  chk_pick_channel: assert property (@(posedge ref_clk) disable iff (rst)
    rx_enable && opctl_r[OMC_OC_RX_ONE] |-> rx_pm_active == channel_pick)
    else $error("one-channel mode ignores channel pick");
  chk_auto_select: assert property (@(posedge ref_clk) disable iff (rst)
    rx_enable && !opctl_r[OMC_OC_RX_ONE] |-> rx_auto_select == !opctl_r[OMC_OC_RX_MAN])
    else $error("channel choice method wrong");
  chk_auto_one: assert property (@(posedge ref_clk) disable iff (rst)
    opctl_r[OMC_OC_RX_ONE] |-> !rx_auto_select)
    else $error("automatic choice with one channel");
endmodule : omc_top

/* testbench/operation_mode_control_tb.sv */
// Self-checking bench for the operation control and mode definition registers
`timescale 1ns/10ps
module operation_mode_control_tb;
  import omc_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, channel_pick = 1'b0, tx_done = 1'b0;
  logic osc_reg_on, ready_mode, rx_enable, rx_am_active, rx_pm_active, rx_auto_select;
  logic tx_enable, wake_mode_enable, target_role, mode_supported, auto_response_collision_avoid;
  logic [3:0] op_mode_field;
  omc_mode_t op_mode, em;
  logic [32:0] exp_q[$];
  logic [32:0] ex;
  logic [7:0] d;
  int err_total = 0, n_tests = 0, cyc = 0, seed = 20;

  omc_top i_dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .channel_pick, .tx_done, .osc_reg_on, .ready_mode, .rx_enable, .rx_am_active,
    .rx_pm_active, .rx_auto_select, .tx_enable, .wake_mode_enable, .target_role,
    .op_mode_field, .op_mode, .mode_supported, .auto_response_collision_avoid);

  always #20 ref_clk = ~ref_clk;

  // ---------------------------------------------------------------
  // Reporting and bus tasks
  // ---------------------------------------------------------------
  task results;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task pulse_done;
    tx_done <= 1'b1;
    @(posedge ref_clk);
    tx_done <= 1'b0;
    @(posedge ref_clk);
  endtask : pulse_done

  function automatic omc_mode_t emode(input logic t, input logic [3:0] c);
    if (t) begin
      if (c == 4'h0) return OMC_OM_T_PEER_DET;
      if (c == 4'h1) return OMC_OM_T_PEER_NORM;
      return OMC_OM_NONE;
    end
    case (c)
      4'h0: return OMC_OM_I_PEER;
      4'h1: return OMC_OM_I_14A;
      4'h2: return OMC_OM_I_14B;
      4'h3: return OMC_OM_I_PROP;
      4'h4: return OMC_OM_I_T1T;
      4'he: return OMC_OM_I_SUBC;
      4'hf: return OMC_OM_I_BPSK;
      default: return OMC_OM_NONE;
    endcase
  endfunction : emode

  // ---------------------------------------------------------------
  // Read monitor and timeout
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (psel && penable && pready && !pwrite) begin
      ex = exp_q.pop_front();
      chk({31'h0, pslverr}, {31'h0, ex[32]}, "error flag");
      chk(prdata, ex[31:0], "read data");
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(OMC_OPCTL_ADDR, 32'h0, 1'b0);
    rd(OMC_MODE_ADDR, 32'h8, 1'b0);
    repeat (8) begin
      d = 8'($random(seed));
      channel_pick <= d[0];
      wr(OMC_OPCTL_ADDR, {d, d, d, d});
      rd(OMC_OPCTL_ADDR, {24'h0, d & 8'hfc}, 1'b0);
      @(negedge ref_clk);
      chk({osc_reg_on, ready_mode, rx_enable, tx_enable, wake_mode_enable},
        {d[7], d[7], d[6], d[3], d[2]}, "control levels");
      chk({rx_am_active, rx_pm_active, rx_auto_select}, {d[6] & !(d[5] & channel_pick),
        d[6] & !(d[5] & !channel_pick), d[6] & !d[5] & !d[4]}, "rx channels");
      @(posedge ref_clk);
    end
    wr(OMC_OPCTL_ADDR, 32'h48);
    for (int i = 0; i < 32; i++) begin
      d = {i[4], i[3:0], 2'b11, i[0]};
      em = emode(d[7], d[6:3]);
      wr(OMC_MODE_ADDR, {24'h0, d});
      rd(OMC_MODE_ADDR, {24'h0, d & 8'hf9}, 1'b0);
      @(negedge ref_clk);
      chk(op_mode, em, "mode decode");
      chk({mode_supported, rx_enable, tx_enable}, {3{em != OMC_OM_NONE}}, "gating");
      chk({target_role, op_mode_field, auto_response_collision_avoid}, {d[7], d[6:3], d[0]},
        "mode fields");
      @(posedge ref_clk);
    end
    wr(12'h020, 32'hff);
    rd(12'h020, 32'h0, 1'b1);
    wr(OMC_OPCTL_ADDR, 32'hfc);
    wr(OMC_MODE_ADDR, 32'hf9);
    rd(OMC_STAT_ADDR, {27'h0, 1'b0, OMC_OM_NONE}, 1'b0);
    wr(OMC_CMD_ADDR, 32'h1);
    rd(OMC_OPCTL_ADDR, 32'hfc, 1'b0);
    rd(OMC_MODE_ADDR, 32'h08, 1'b0);
    wr(OMC_OPCTL_ADDR, 32'h80);
    wr(OMC_MODE_ADDR, 32'h00);
    rd(OMC_STAT_ADDR, {27'h0, 1'b1, OMC_OM_I_PEER}, 1'b0);
    rd(OMC_CMD_ADDR, 32'h0, 1'b0);
    wr(OMC_CMD_ADDR, 32'h2);
    rd(OMC_OPCTL_ADDR, 32'h88, 1'b0);
    pulse_done();
    rd(OMC_OPCTL_ADDR, 32'h80, 1'b0);
    wr(OMC_MODE_ADDR, 32'h08);
    wr(OMC_CMD_ADDR, 32'h2);
    pulse_done();
    rd(OMC_OPCTL_ADDR, 32'h88, 1'b0);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(OMC_OPCTL_ADDR, 32'h0, 1'b0);
    rd(OMC_MODE_ADDR, 32'h08, 1'b0);
    repeat (3) @(posedge ref_clk);
    results();
  end
endmodule : operation_mode_control_tb
